// file: design/motion_hs_regs.svh
`ifndef MOTION_HS_REGS_SVH
`define MOTION_HS_REGS_SVH

`define NUM_TASKS        6
`define REG_START_OFS    4'h0
`define REG_STATUS_OFS   4'h4
`define START_RESET      6'h00
`define BUSY_LSB         0
`define DONE_LSB         8
`define ABORT_LSB        16
`define ERROR_LSB        24
`define DONE_TYPE_MASK   6'h1f
`define ABORTABLE_MASK   6'h3e
`define ONE_TASK         6'h01
`define RDATA_ZERO       32'h0000_0000

`endif

// file: design/motion_hs_pkg.sv
`include "motion_hs_regs.svh"

package motion_hs_pkg;

	typedef enum logic [2:0] {
		TASK_FAULT_CLEAR = 3'h0,
		TASK_HOMING      = 3'h1,
		TASK_STOP        = 3'h2,
		TASK_ABSOLUTE    = 3'h3,
		TASK_RELATIVE    = 3'h4,
		TASK_SPEED       = 3'h5
	} task_id_t;

	typedef logic [`NUM_TASKS-1:0] task_vec_t;

	// Reports from the axis motion engine, one bit per task where it applies.
	typedef struct packed {
		task_vec_t done;
		task_vec_t error;
		logic      speed_reached;
	} engine_report_t;

	// Handshake outputs; aborted covers tasks 1..5 only, fault clear has none.
	typedef struct packed {
		task_vec_t                 busy;
		logic [`NUM_TASKS-2:0]     done;
		logic [`NUM_TASKS-2:0]     task_aborted;
		logic                      at_target_speed;
		task_vec_t                 error;
	} task_status_t;

	typedef struct packed {
		task_vec_t   start;
		task_vec_t   busy;
		task_vec_t   done;
		task_vec_t   aborted;
		task_vec_t   error;
		logic        at_speed;
		logic        reached;
		task_vec_t   launch;
		logic        ack;
		logic [31:0] rdata;
	} state_t;

endpackage : motion_hs_pkg

// file: design/motion_task_status_handshake.sv
`timescale 1ns/100ps
`include "motion_hs_regs.svh"

// Contract
// - start input launches task; runs to standstill.
// - completion only on successful finish.
// - fault clear never aborted, no aborted output.
// - busy while processing; drops on any end.
// - status flags latched while start stays high.
// - completion handshake for five defined-end tasks.
// - start already low: completion one cycle.
// - superseded task drops busy, raises aborted.
// - aborted held until start falls.
// - start already low: aborted one cycle.
// - error held until start falls.
// - start already low: error one cycle.
// - at-speed rises when velocity first reached.
// - speed task completes: reached and start low.
// - start high: at-speed, busy fall with start.
// - start low early: at-speed one cycle.
// - completed speed task never reports aborted.
// - error before speed reached: busy off, error.
// - error after completion not reported here.
module motion_task_status_handshake (
	input  wire logic                         core_clk,
	input  wire logic                         rst,
	input  wire logic [3:0]                   avs_address,
	input  wire logic                         avs_read,
	input  wire logic                         avs_write,
	input  wire logic [31:0]                  avs_writedata,
	input  wire logic [3:0]                   avs_byteenable,
	output logic      [31:0]                  avs_readdata,
	output logic                              avs_waitrequest,
	input  wire motion_hs_pkg::engine_report_t report,
	output motion_hs_pkg::task_vec_t          launch,
	output motion_hs_pkg::task_status_t       status
);

	localparam int SP  = int'(motion_hs_pkg::TASK_SPEED);
	localparam int FC  = int'(motion_hs_pkg::TASK_FAULT_CLEAR);
	localparam int HOM = int'(motion_hs_pkg::TASK_HOMING);
	localparam int ABS = int'(motion_hs_pkg::TASK_ABSOLUTE);
	localparam int REL = int'(motion_hs_pkg::TASK_RELATIVE);

	localparam motion_hs_pkg::task_vec_t ABORTABLE = `ABORTABLE_MASK;

	motion_hs_pkg::state_t s_q;
	motion_hs_pkg::state_t s_d;
	logic                  req;

	// A flag is set by its event and then follows the start level; the event wins.
	function automatic logic flag_next(
		input logic ev,
		input logic q,
		input logic start_n,
		input logic launch_n
	);
		flag_next = ev | (q & start_n & ~launch_n);
	endfunction : flag_next

	function automatic motion_hs_pkg::task_vec_t one_hot(input int idx);
		one_hot = motion_hs_pkg::task_vec_t'(`ONE_TASK << idx);
	endfunction : one_hot

	assign req = avs_read | avs_write;

	always_comb begin
		motion_hs_pkg::task_vec_t start_n;
		motion_hs_pkg::task_vec_t launch_n;
		motion_hs_pkg::task_vec_t motion_launch;
		motion_hs_pkg::task_vec_t ev_done;
		motion_hs_pkg::task_vec_t ev_abort;
		motion_hs_pkg::task_vec_t ev_err;
		logic                     ev_reach;
		start_n       = s_q.start;
		launch_n      = '0;
		motion_launch = '0;
		ev_done       = '0;
		ev_abort      = '0;
		ev_err        = '0;
		ev_reach      = 1'b0;
		s_d           = s_q;
		s_d.ack       = req & ~s_q.ack;

		if (avs_write && s_q.ack && avs_address == `REG_START_OFS && avs_byteenable[0]) begin
			start_n = avs_writedata[`NUM_TASKS-1:0];
		end
		launch_n      = start_n & ~s_q.start;
		motion_launch = launch_n & `ABORTABLE_MASK;

		for (int i = 0; i < `NUM_TASKS; i++) begin
			if ((motion_launch & ~one_hot(i)) != '0) begin
				ev_abort[i] = s_q.busy[i] & ABORTABLE[i];
			end
		end
		ev_done  = s_q.busy & report.done & `DONE_TYPE_MASK;
		ev_err   = s_q.busy & report.error;
		ev_reach = s_q.busy[SP] & report.speed_reached & ~s_q.reached;

		s_d.reached = ~launch_n[SP] & (s_q.reached | ev_reach);
		s_d.busy    = (s_q.busy & ~(ev_done | ev_abort | ev_err)) | launch_n;
		if (s_q.at_speed && !start_n[SP]) begin
			s_d.busy[SP] = 1'b0;
		end
		for (int i = 0; i < `NUM_TASKS; i++) begin
			s_d.done[i]    = flag_next(ev_done[i], s_q.done[i], start_n[i], launch_n[i]);
			s_d.aborted[i] = flag_next(ev_abort[i], s_q.aborted[i], start_n[i], launch_n[i]);
			s_d.error[i]   = flag_next(ev_err[i], s_q.error[i], start_n[i], launch_n[i]);
		end
		s_d.at_speed = ev_reach | (s_q.at_speed & start_n[SP] & s_d.busy[SP]);
		s_d.start    = start_n;
		s_d.launch   = launch_n;

		if (avs_read && !s_q.ack) begin
			s_d.rdata = `RDATA_ZERO;
			case (avs_address)
				`REG_START_OFS: begin
					s_d.rdata[`NUM_TASKS-1:0] = s_q.start;
				end
				`REG_STATUS_OFS: begin
					s_d.rdata[`BUSY_LSB +: `NUM_TASKS]  = s_q.busy;
					s_d.rdata[`DONE_LSB +: `NUM_TASKS]  = {s_q.at_speed, s_q.done[`NUM_TASKS-2:0]};
					s_d.rdata[`ABORT_LSB +: `NUM_TASKS] = s_q.aborted & `ABORTABLE_MASK;
					s_d.rdata[`ERROR_LSB +: `NUM_TASKS] = s_q.error;
				end
				default: begin
					s_d.rdata = `RDATA_ZERO;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			s_q       <= '0;
			s_q.start <= `START_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	assign avs_waitrequest        = req & ~s_q.ack;
	assign avs_readdata           = s_q.rdata;
	assign launch                 = s_q.launch;
	assign status.busy            = s_q.busy;
	assign status.done            = s_q.done[`NUM_TASKS-2:0];
	assign status.task_aborted    = s_q.aborted[`NUM_TASKS-1:1];
	assign status.at_target_speed = s_q.at_speed;
	assign status.error           = s_q.error;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	launch_sets_busy_a: assert property ($rose(s_q.start[HOM]) |-> s_q.busy[HOM] && s_q.launch[HOM])
		else $error("start edge did not launch task");
	done_needs_cause_a: assert property ($rose(s_q.done[ABS]) |-> $past(s_q.busy[ABS] && report.done[ABS]))
		else $error("completion without successful finish");
	fault_no_abort_a: assert property (s_q.busy[FC] && !report.done[FC] && !report.error[FC] |=> s_q.busy[FC])
		else $error("fault clear task was aborted");
	busy_drop_a: assert property (s_q.busy[REL] && report.done[REL] && !s_q.launch[REL] ##1 !$rose(s_q.start[REL])
		|-> !s_q.busy[REL] && s_q.done[REL])
		else $error("busy did not drop on completion");
	done_pulse_a: assert property ($rose(s_q.done[HOM]) && !s_q.start[HOM] |=> !s_q.done[HOM])
		else $error("completion longer than one cycle");
	done_latch_a: assert property (s_q.done[HOM] && s_q.start[HOM] |=> s_q.done[HOM] == s_q.start[HOM])
		else $error("completion not latched with start");
	supersede_a: assert property ($rose(s_q.start[REL]) && $past(s_q.busy[ABS]) |-> s_q.aborted[ABS] && !s_q.busy[ABS])
		else $error("superseded task not aborted");
	abort_hold_a: assert property (s_q.aborted[ABS] && s_q.start[ABS] |=> s_q.aborted[ABS] == s_q.start[ABS])
		else $error("aborted not held with start");
	abort_pulse_a: assert property ($rose(s_q.aborted[ABS]) && !s_q.start[ABS] |=> !s_q.aborted[ABS])
		else $error("aborted longer than one cycle");
	error_hold_a: assert property (s_q.error[REL] && s_q.start[REL] |=> s_q.error[REL] == s_q.start[REL])
		else $error("error not held with start");
	error_pulse_a: assert property ($rose(s_q.error[REL]) && !s_q.start[REL] |=> !s_q.error[REL])
		else $error("error longer than one cycle");
	speed_reach_a: assert property (s_q.busy[SP] && report.speed_reached && !s_q.reached && !report.error[SP]
		&& s_q.launch == '0 ##1 !$fell(s_q.start[SP]) |-> s_q.at_speed)
		else $error("at-speed missing on first reach");
	speed_done_a: assert property (s_q.at_speed && !s_q.start[SP] |=> !s_q.at_speed && (!s_q.busy[SP] || s_q.start[SP]))
		else $error("speed task did not complete");
	speed_hold_a: assert property (s_q.at_speed && s_q.start[SP] |=> s_q.at_speed == s_q.busy[SP])
		else $error("at-speed and busy split");
	speed_oneshot_a: assert property ($rose(s_q.at_speed) && !s_q.start[SP] |=> !s_q.at_speed)
		else $error("at-speed longer than one cycle");
	speed_no_abort_a: assert property (!s_q.busy[SP] |=> !$rose(s_q.aborted[SP]))
		else $error("completed speed task aborted");
	speed_error_a: assert property (s_q.busy[SP] && !s_q.reached && report.error[SP] |=> s_q.error[SP] && !s_q.busy[SP])
		else $error("error before reach not reported");
	idle_no_error_a: assert property (!s_q.busy[SP] |=> !$rose(s_q.error[SP]))
		else $error("error reported after completion");

	done_latched_c: cover property (s_q.done[HOM] && s_q.start[HOM] ##1 s_q.done[HOM]);
	abort_seen_c: cover property ($rose(s_q.aborted[ABS]));
	speed_held_c: cover property (s_q.at_speed && s_q.start[SP] ##1 !s_q.start[SP]);
	error_pulse_c: cover property ($rose(s_q.error[REL]) && !s_q.start[REL]);

endmodule : motion_task_status_handshake

// file: verification/axis_engine_model.sv
`timescale 1ns/100ps
// Stands in for the axis motion engine: replays the commanded report one cycle later.
module axis_engine_model (
	input  wire logic                          core_clk,
	input  wire logic                          rst,
	input  wire motion_hs_pkg::task_vec_t      launch,
	input  wire motion_hs_pkg::engine_report_t cmd,
	output motion_hs_pkg::engine_report_t      report
);
	always_ff @(posedge core_clk) begin
		if (rst) begin
			report <= '0;
		end else begin
			// A task cannot finish in the cycle it is launched.
			report      <= cmd;
			report.done <= cmd.done & ~launch;
		end
	end
endmodule : axis_engine_model

// file: verification/motion_task_status_handshake_bench.sv
`timescale 1ns/100ps
module motion_task_status_handshake_bench;
	typedef struct packed {
		logic [31:0]                   start;
		motion_hs_pkg::engine_report_t ev;
		logic [31:0]                   held;
	} row_t;
	logic                          core_clk = 1'b0;
	logic                          rst = 1'b1;
	logic [3:0]                    avs_address = 4'h0;
	logic                          avs_read = 1'b0;
	logic                          avs_write = 1'b0;
	logic [31:0]                   avs_writedata = 32'h0000_0000;
	logic [31:0]                   avs_readdata;
	logic                          avs_waitrequest;
	motion_hs_pkg::engine_report_t cmd = '0;
	motion_hs_pkg::engine_report_t report;
	motion_hs_pkg::task_vec_t      launch;
	motion_hs_pkg::task_status_t   status;
	logic [31:0]                   rv;
	int                            n_errors = 0;
	int                            check_count = 0;
	int                            cycles = 0;
	row_t                          rows [8];

	always #20 core_clk = ~core_clk;

	motion_task_status_handshake motion_task_status_handshake_inst (
		.core_clk(core_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .report(report),
		.launch(launch), .status(status));
	axis_engine_model axis_engine_model_inst (
		.core_clk(core_clk), .rst(rst), .launch(launch), .cmd(cmd), .report(report));

	task print_verdict;
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : print_verdict

	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 4000) begin
			n_errors++;
			print_verdict();
		end
	end

	task check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask : check

	// The request stands until the rising edge at which waitrequest is seen low; only the timeout ends a hang.
	task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk);
		avs_address   <= a;
		avs_writedata <= d;
		avs_write     <= wr;
		avs_read      <= ~wr;
		do begin
			@(posedge core_clk);
		end while (avs_waitrequest !== 1'b0);
		rv = avs_readdata;
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
	endtask : bus

	task wr(input logic [31:0] d);
		bus(1'b1, 4'h0, d);
	endtask : wr

	task rd(input logic [3:0] a);
		bus(1'b0, a, 32'h0000_0000);
	endtask : rd

	task ev(input motion_hs_pkg::engine_report_t e);
		@(posedge core_clk);
		cmd <= e;
		@(posedge core_clk);
		cmd <= '0;
	endtask : ev

	// Counts the cycles in which any status flag other than busy is up.
	task flags(input int want);
		int c;
		c = 0;
		repeat (12) begin
			@(negedge core_clk);
			if ((|{status.done, status.task_aborted, status.at_target_speed, status.error}) === 1'b1) c++;
		end
		check(32'(c), 32'(want));
	endtask : flags

	initial begin
		rows = '{'{32'h0000_0001, {6'h01, 6'h00, 1'b0}, 32'h0000_0100},
			'{32'h0000_0002, {6'h02, 6'h00, 1'b0}, 32'h0000_0200},
			'{32'h0000_0004, {6'h04, 6'h00, 1'b0}, 32'h0000_0400},
			'{32'h0000_0008, {6'h08, 6'h00, 1'b0}, 32'h0000_0800},
			'{32'h0000_0010, {6'h10, 6'h00, 1'b0}, 32'h0000_1000},
			'{32'h0000_0008, {6'h00, 6'h08, 1'b0}, 32'h0800_0000},
			'{32'h0000_0020, {6'h00, 6'h00, 1'b1}, 32'h0000_2020},
			'{32'h0000_0020, {6'h00, 6'h20, 1'b0}, 32'h2000_0000}};
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		rd(4'h4);
		check(rv, 32'h0000_0000);
		rd(4'h8);
		check(rv, 32'h0000_0000);
		bus(1'b1, 4'h4, 32'hffff_ffff);
		rd(4'h4);
		check(rv, 32'h0000_0000);
		$display("reset test ended");
		foreach (rows[i]) begin
			wr(rows[i].start);
			ev(rows[i].ev);
			rd(4'h4);
			check(rv, rows[i].held);
			wr(32'h0000_0000);
			rd(4'h4);
			check(rv, 32'h0000_0000);
			$display("row %0d ended", i);
		end
		wr(32'h0000_0008);
		wr(32'h0000_0000);
		ev({6'h08, 6'h00, 1'b0});
		flags(1);
		wr(32'h0000_0009);
		wr(32'h0000_0019);
		rd(4'h4);
		check(rv, 32'h0008_0011);
		wr(32'h0000_0011);
		rd(4'h4);
		check(rv, 32'h0000_0011);
		ev({6'h11, 6'h00, 1'b0});
		wr(32'h0000_0000);
		$display("abort held test ended");
		wr(32'h0000_0004);
		wr(32'h0000_0000);
		wr(32'h0000_0010);
		flags(1);
		ev({6'h10, 6'h00, 1'b0});
		wr(32'h0000_0000);
		wr(32'h0000_0002);
		wr(32'h0000_0000);
		ev({6'h00, 6'h02, 1'b0});
		flags(1);
		wr(32'h0000_0020);
		wr(32'h0000_0000);
		ev({6'h00, 6'h00, 1'b1});
		flags(1);
		wr(32'h0000_0004);
		ev({6'h00, 6'h20, 1'b0});
		flags(0);
		ev({6'h04, 6'h00, 1'b0});
		wr(32'h0000_0000);
		rd(4'h4);
		check(rv, 32'h0000_0000);
		$display("single cycle tests ended");
		print_verdict();
	end
endmodule : motion_task_status_handshake_bench
